// file: include/slp_pkg.sv
// package: constants, states and state record of the sleep controller
`default_nettype none
package slp_pkg;
    // sleep mode selector encodings
    localparam logic [2:0] SLP_M_IDLE    = 3'h0;
    localparam logic [2:0] SLP_M_ADCNR   = 3'h1;
    localparam logic [2:0] SLP_M_PDOWN   = 3'h2;
    localparam logic [2:0] SLP_M_PSAVE   = 3'h3;
    localparam logic [2:0] SLP_M_STANDBY = 3'h6;
    // register byte offsets on the bus
    localparam logic [7:0] SLP_A_MODE    = 8'h00;
    localparam logic [7:0] SLP_A_PWRRED  = 8'h04;
    localparam logic [7:0] SLP_A_STATUS  = 8'h08;
    localparam logic [7:0] SLP_A_MCUCTL  = 8'h0C;
    // field positions
    localparam int SLP_F_SE      = 0;
    localparam int SLP_F_SM_LO   = 1;
    localparam int SLP_F_SCANDIS = 7;
    localparam int SLP_F_XTAL    = 3;
    localparam int SLP_F_LONGSU  = 0;
    // power reduction bit numbers
    localparam int SLP_PR_ADC   = 0;
    localparam int SLP_PR_LCD   = 4;
    localparam int SLP_NPER     = 5;
    // reset values
    localparam logic [2:0] SLP_RST_SM    = 3'h0;
    localparam logic [4:0] SLP_RST_PRR   = 5'h00;
    // cycle counts
    localparam logic [10:0] SLP_SU_SHORT_CYC = 11'h010;
    localparam logic [10:0] SLP_SU_LONG_CYC  = 11'h400;
    localparam logic [10:0] SLP_STANDBY_CYC  = 11'h006;
    localparam logic [10:0] SLP_HALT_CYC     = 11'h004;

    typedef enum logic [1:0] {
        SLP_ACTIVE,
        SLP_SLEEP,
        SLP_WAKE,
        SLP_HALT
    } slp_state_e;

    typedef struct packed {
        slp_state_e                st;
        logic [2:0]                sm;
        logic                      se;
        logic [SLP_NPER-1:0]       power_reduction_reg;
        logic                      scan_dis;
        logic [2:0]                mode;
        logic [10:0]               cnt;
        logic                      ack;
        logic [31:0]               rdat;
        logic                      i0_m;
        logic                      i0;
        logic                      pc_m;
        logic                      pc;
        logic                      adc_en_d;
        logic                      adc_ext;
        logic                      adc_start;
        logic                      wake;
        logic                      cpu;
        logic                      io;
        logic                      adc;
        logic                      asy;
        logic                      main;
        logic                      tosc;
        logic                      inbuf;
        logic                      cmp_off;
        logic                      vref;
        logic [SLP_NPER-1:0]       per;
    } slp_regs_s;
endpackage
`default_nettype wire

// file: verilog/slp_ctrl.sv
// sleep mode and power reduction controller with wishbone registers
//
// Implementation choices: the register addresses and the Wishbone register port.
`default_nettype none
module slp_ctrl
    import slp_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic                     wb_ack_o,
    output logic [31:0]              wb_dat_o,
    // core side
    input  wire logic                sleep_instr_i,
    input  wire logic                irq_any_i,
    input  wire logic                global_ie_i,
    input  wire logic                reset_wake_i,
    // wake sources from peripherals
    input  wire logic                adc_done_irq_i,
    input  wire logic                lcd_irq_i,
    input  wire logic                usi_start_irq_i,
    input  wire logic                t2_ovf_flag_i,
    input  wire logic                t2_cmp_flag_i,
    input  wire logic [1:0]          timer2_interrupt_mask_i,
    input  wire logic                spm_ee_irq_i,
    input  wire logic                ext_int_zero_level_i,
    input  wire logic                pin_change_i,
    // module configuration
    input  wire logic                adc_enable_i,
    input  wire logic                adc_conv_start_i,
    input  wire logic                comparator_disable_i,
    input  wire logic                comparator_uses_ref_i,
    input  wire logic                wdt_enable_i,
    input  wire logic                t2_async_i,
    input  wire logic                lcd_async_i,
    input  wire logic                t2_sync_i,
    input  wire logic                lcd_sync_i,
    // fuses
    input  wire logic [3:0]          clock_source_fuses_i,
    input  wire logic [2:0]          brownout_level_fuses_i,
    input  wire logic                on_chip_debug_fuse_i,
    input  wire logic                scan_port_enable_fuse_i,
    // clock and power controls
    output logic                     clk_cpu_en_o,
    output logic                     clk_flash_en_o,
    output logic                     clk_io_en_o,
    output logic                     clk_adc_en_o,
    output logic                     clk_asy_en_o,
    output logic                     main_osc_en_o,
    output logic                     timer_osc_en_o,
    output logic [SLP_NPER-1:0]      periph_clk_en_o,
    output logic [SLP_NPER-1:0]      periph_io_block_o,
    output logic                     core_halt_o,
    output logic                     wake_o,
    output logic                     adc_start_o,
    output logic                     adc_extended_o,
    output logic                     adc_active_o,
    output logic                     comparator_off_o,
    output logic                     vref_en_o,
    output logic                     bod_active_o,
    output logic                     wdt_active_o,
    output logic                     input_buf_en_o,
    output logic                     scan_port_en_o
);
    slp_regs_s s_r;
    slp_regs_s s_nxt;
    logic      bus_req;
    logic      bod_en;
    logic      xtal;
    logic [2:0] eff_mode;
    logic      wake_ev;
    logic      enter;
    logic      t2_async_use;
    logic      t2_sync_use;

    // requests are answered one cycle after strobe, ack lasts one cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
    // brown-out detector counts as enabled unless all level fuses are 1
    assign bod_en = (brownout_level_fuses_i != 3'h7);
    assign xtal   = clock_source_fuses_i[SLP_F_XTAL];
    assign t2_async_use = t2_async_i || lcd_async_i;
    assign t2_sync_use  = t2_sync_i || lcd_sync_i;
    assign enter  = (s_r.st == SLP_ACTIVE) && sleep_instr_i && s_r.se;

    // reserved codes and Standby without a crystal fall back to Idle
    always_comb begin
        case (s_r.sm)
            SLP_M_IDLE, SLP_M_ADCNR, SLP_M_PDOWN, SLP_M_PSAVE:
                eff_mode = s_r.sm;
            SLP_M_STANDBY:
                eff_mode = xtal ? SLP_M_STANDBY : SLP_M_IDLE;
            default:
                eff_mode = SLP_M_IDLE;
        endcase
    end

    // wake events allowed in the mode that is being slept in
    always_comb begin
        case (s_r.mode)
            SLP_M_IDLE:
                wake_ev = irq_any_i || reset_wake_i;
            SLP_M_ADCNR:
                wake_ev = adc_done_irq_i || reset_wake_i || lcd_irq_i
                       || usi_start_irq_i || t2_ovf_flag_i
                       || t2_cmp_flag_i || spm_ee_irq_i
                       || s_r.i0 || s_r.pc;
            SLP_M_PSAVE:
                wake_ev = reset_wake_i || usi_start_irq_i || s_r.i0
                       || s_r.pc || lcd_irq_i
                       || (global_ie_i && ((t2_ovf_flag_i
                           && timer2_interrupt_mask_i[0])
                           || (t2_cmp_flag_i
                           && timer2_interrupt_mask_i[1])));
            default:
                wake_ev = reset_wake_i || usi_start_irq_i
                       || s_r.i0 || s_r.pc;
        endcase
    end

    // whole next-state computation
    always_comb begin
        logic slp;
        logic io_run;
        logic adc_run;
        logic dbg_hold;
        slp      = 1'b0;
        io_run   = 1'b0;
        adc_run  = 1'b0;
        dbg_hold = 1'b0;
        s_nxt    = s_r;
        s_nxt.ack       = bus_req;
        s_nxt.adc_start = 1'b0;
        s_nxt.wake      = 1'b0;
        // level wake pins pass two flops; the source must hold them
        s_nxt.i0_m = ext_int_zero_level_i;
        s_nxt.i0   = s_r.i0_m;
        s_nxt.pc_m = pin_change_i;
        s_nxt.pc   = s_r.pc_m;

        // switching the converter off arms an extended conversion;
        // the arming wins over a start seen in the same cycle
        s_nxt.adc_en_d = adc_enable_i;
        if (s_r.adc_en_d && !adc_enable_i) begin
            s_nxt.adc_ext = 1'b1;
        end else if (adc_conv_start_i || s_r.adc_start) begin
            s_nxt.adc_ext = 1'b0;
        end

        // register reads and writes, unmapped reads return zero
        if (bus_req) begin
            s_nxt.rdat = 32'h0000_0000;
            case (wb_adr_i)
                SLP_A_MODE: begin
                    s_nxt.rdat[3:0] = {s_r.sm, s_r.se};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.se = wb_dat_i[SLP_F_SE];
                        s_nxt.sm = wb_dat_i[SLP_F_SM_LO +: 3];
                    end
                end
                SLP_A_PWRRED: begin
                    s_nxt.rdat[SLP_NPER-1:0] = s_r.power_reduction_reg;
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.power_reduction_reg = wb_dat_i[SLP_NPER-1:0];
                    end
                end
                SLP_A_STATUS: begin
                    s_nxt.rdat[11:0] = {s_r.cpu, s_r.io, s_r.adc, s_r.asy,
                                        s_r.main, s_r.tosc, s_r.mode,
                                        s_r.adc_ext, s_r.st};
                end
                SLP_A_MCUCTL: begin
                    s_nxt.rdat[SLP_F_SCANDIS] = s_r.scan_dis;
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.scan_dis = wb_dat_i[SLP_F_SCANDIS];
                    end
                end
                default: begin
                    s_nxt.rdat = 32'h0000_0000;
                end
            endcase
        end

        // sleep sequencer
        case (s_r.st)
            SLP_ACTIVE: begin
                if (enter) begin
                    s_nxt.st   = SLP_SLEEP;
                    s_nxt.mode = eff_mode;
                    s_nxt.adc_start = adc_enable_i
                        && (eff_mode == SLP_M_IDLE
                            || eff_mode == SLP_M_ADCNR);
                end
            end
            SLP_SLEEP: begin
                if (wake_ev) begin
                    case (s_r.mode)
                        SLP_M_PDOWN, SLP_M_PSAVE: begin
                            s_nxt.st  = SLP_WAKE;
                            s_nxt.cnt = (clock_source_fuses_i[SLP_F_LONGSU]
                                ? SLP_SU_LONG_CYC : SLP_SU_SHORT_CYC)
                                - 11'h001;
                        end
                        SLP_M_STANDBY: begin
                            s_nxt.st  = SLP_WAKE;
                            s_nxt.cnt = SLP_STANDBY_CYC - 11'h001;
                        end
                        default: begin
                            s_nxt.st  = SLP_HALT;
                            s_nxt.cnt = SLP_HALT_CYC - 11'h001;
                        end
                    endcase
                end
            end
            SLP_WAKE: begin
                s_nxt.cnt = s_r.cnt - 11'h001;
                if (s_r.cnt == 11'h000) begin
                    s_nxt.st  = SLP_HALT;
                    s_nxt.cnt = SLP_HALT_CYC - 11'h001;
                end
            end
            SLP_HALT: begin
                s_nxt.cnt = s_r.cnt - 11'h001;
                if (s_r.cnt == 11'h000) begin
                    s_nxt.st   = SLP_ACTIVE;
                    s_nxt.wake = 1'b1;
                end
            end
            default: begin
                s_nxt.st = SLP_ACTIVE;
            end
        endcase

        // clock domain enables follow the state; clocks restart at halt
        slp     = (s_r.st == SLP_SLEEP) || (s_r.st == SLP_WAKE);
        io_run  = !slp || s_r.mode == SLP_M_IDLE;
        adc_run = !slp || s_r.mode == SLP_M_IDLE
                       || s_r.mode == SLP_M_ADCNR;
        dbg_hold = on_chip_debug_fuse_i && scan_port_enable_fuse_i
                && !s_r.scan_dis;
        s_nxt.cpu = !slp;
        s_nxt.io  = io_run;
        s_nxt.adc = adc_run;
        s_nxt.asy = adc_run
                 || (s_r.mode == SLP_M_PSAVE && s_r.st == SLP_SLEEP);
        s_nxt.tosc = adc_run || (s_r.mode == SLP_M_PSAVE
                 && t2_async_use);
        s_nxt.main = adc_run || s_r.st == SLP_WAKE
                 || s_r.mode == SLP_M_STANDBY
                 || (s_r.mode == SLP_M_PSAVE && t2_sync_use)
                 || ((s_r.mode == SLP_M_PDOWN
                      || s_r.mode == SLP_M_PSAVE) && dbg_hold);
        // buffers for wake pins are outside this gate and stay on
        s_nxt.inbuf   = io_run || adc_run;
        s_nxt.cmp_off = comparator_disable_i || !adc_run;
        // reference tracks its users, independent of sleep
        s_nxt.vref = bod_en || adc_enable_i
                  || (comparator_uses_ref_i && !comparator_disable_i);
        // gating only bites where the io clock would otherwise run
        s_nxt.per = ~s_r.power_reduction_reg & {SLP_NPER{io_run}};
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r          <= '0;
            s_r.st       <= SLP_ACTIVE;
            s_r.sm       <= SLP_RST_SM;
            s_r.power_reduction_reg      <= SLP_RST_PRR;
            s_r.cpu      <= 1'b1;
            s_r.io       <= 1'b1;
            s_r.adc      <= 1'b1;
            s_r.asy      <= 1'b1;
            s_r.main     <= 1'b1;
            s_r.tosc     <= 1'b1;
            s_r.inbuf    <= 1'b1;
            s_r.cmp_off  <= 1'b1;
            s_r.per      <= {SLP_NPER{1'b1}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o          = s_r.ack;
    assign wb_dat_o          = s_r.rdat;
    assign clk_cpu_en_o      = s_r.cpu;
    assign clk_flash_en_o    = s_r.cpu;
    assign clk_io_en_o       = s_r.io;
    assign clk_adc_en_o      = s_r.adc;
    assign clk_asy_en_o      = s_r.asy;
    assign main_osc_en_o     = s_r.main;
    assign timer_osc_en_o    = s_r.tosc;
    assign periph_clk_en_o   = s_r.per;
    assign periph_io_block_o = s_r.power_reduction_reg;
    assign core_halt_o       = (s_r.st != SLP_ACTIVE);
    assign wake_o            = s_r.wake;
    assign adc_start_o       = s_r.adc_start;
    assign adc_extended_o    = s_r.adc_ext;
    assign adc_active_o      = s_r.adc_en_d;
    assign comparator_off_o  = s_r.cmp_off;
    assign vref_en_o         = s_r.vref;
    assign bod_active_o      = bod_en;
    assign wdt_active_o      = wdt_enable_i;
    assign input_buf_en_o    = s_r.inbuf;
    assign scan_port_en_o    = scan_port_enable_fuse_i && !s_r.scan_dis;

    a_idle_clocks: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_SLEEP && s_r.mode == SLP_M_IDLE)
        |=> (clk_io_en_o && clk_adc_en_o && !clk_cpu_en_o))
        else $error("idle clock set wrong");
    a_se_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_ACTIVE && sleep_instr_i && !s_r.se)
        |=> (s_r.st == SLP_ACTIVE))
        else $error("sleep entered without enable");
    a_adc_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (enter && adc_enable_i && eff_mode == SLP_M_IDLE)
        |=> (adc_start_o ##1 !adc_start_o))
        else $error("no conversion start on entry");
    a_halt_four: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_HALT && $past(s_r.st) != SLP_HALT)
        |-> (s_r.st == SLP_HALT) [*4] ##1 (s_r.st == SLP_ACTIVE && wake_o))
        else $error("halt not four cycles");
    a_stby_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_SLEEP && s_r.mode == SLP_M_STANDBY && wake_ev)
        |=> (s_r.st == SLP_WAKE && main_osc_en_o) [*6]
        ##1 (s_r.st == SLP_HALT))
        else $error("standby wake not six cycles");
    a_pd_nowake: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_SLEEP && s_r.mode == SLP_M_PDOWN && !reset_wake_i
         && !usi_start_irq_i && !s_r.i0 && !s_r.pc)
        |=> (s_r.st == SLP_SLEEP))
        else $error("power-down woke on other event");
    a_psave_tosc: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_SLEEP && s_r.mode == SLP_M_PSAVE && !t2_async_use)
        |=> !timer_osc_en_o)
        else $error("timer oscillator left running");
    a_prr_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == SLP_A_PWRRED
         && wb_dat_i[SLP_PR_LCD])
        |=> ##1 (!periph_clk_en_o[SLP_PR_LCD]
                 && periph_io_block_o[SLP_PR_LCD]))
        else $error("peripheral not frozen");
    a_inbuf_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_r.st == SLP_SLEEP && s_r.mode == SLP_M_PDOWN)
        |=> !input_buf_en_o)
        else $error("input buffers left on");
    a_scan_dis: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == SLP_A_MCUCTL
         && wb_dat_i[SLP_F_SCANDIS])
        |=> !scan_port_en_o)
        else $error("scan port not disabled");
endmodule
`default_nettype wire

// file: tb/slp_wake_model.sv
// wake source model: core and peripherals raising wake lines
`default_nettype none
module slp_wake_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       fire_i,
    input  wire logic [1:0] src_i,
    input  wire logic       wake_i,
    output logic [3:0]      lines_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // a raised line is held until the core resumes, so slow sync paths see it
    always_ff @(posedge clk_i) begin
        if (rst_i || wake_i) begin
            lines_o <= 4'h0;
        end else if (fire_i) begin
            lines_o[src_i] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_slp_ctrl.sv
// testbench: sleep entry, wake timing, power reduction, bus access
`default_nettype none
module tb_slp_ctrl;
    import slp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_instr_i, fire;
    logic global_ie_i, reset_wake_i, adc_done_irq_i, usi_start_irq_i;
    logic t2_ovf_flag_i, t2_cmp_flag_i, spm_ee_irq_i, adc_enable_i;
    logic adc_conv_start_i, comparator_disable_i, comparator_uses_ref_i;
    logic wdt_enable_i, t2_async_i, lcd_async_i, t2_sync_i, lcd_sync_i;
    logic on_chip_debug_fuse_i, scan_port_enable_fuse_i, wb_ack_o, wake_o;
    logic clk_cpu_en_o, clk_flash_en_o, clk_io_en_o, clk_adc_en_o;
    logic clk_asy_en_o, main_osc_en_o, timer_osc_en_o, core_halt_o;
    logic adc_start_o, adc_extended_o, adc_active_o, comparator_off_o;
    logic vref_en_o, bod_active_o, wdt_active_o, input_buf_en_o;
    logic scan_port_en_o, irq_any_i, pin_change_i, ext_int_zero_level_i;
    logic lcd_irq_i;
    logic [1:0]          timer2_interrupt_mask_i, src;
    logic [2:0]          brownout_level_fuses_i;
    logic [3:0]          clock_source_fuses_i, wb_sel_i, lines;
    logic [7:0]          wb_adr_i;
    logic [31:0]         wb_dat_i, wb_dat_o, q;
    logic [SLP_NPER-1:0] periph_clk_en_o, periph_io_block_o;
    int                  errors, total_checks, starts, n;
    assign {lcd_irq_i, ext_int_zero_level_i, pin_change_i, irq_any_i} = lines;
    slp_wake_model slp_wake_model_inst (.clk_i, .rst_i, .fire_i(fire),
        .src_i(src), .wake_i(wake_o), .lines_o(lines));
    slp_ctrl slp_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .sleep_instr_i,
        .irq_any_i, .global_ie_i, .reset_wake_i, .adc_done_irq_i, .lcd_irq_i,
        .usi_start_irq_i, .t2_ovf_flag_i, .t2_cmp_flag_i,
        .timer2_interrupt_mask_i, .spm_ee_irq_i, .ext_int_zero_level_i,
        .pin_change_i, .adc_enable_i, .adc_conv_start_i, .comparator_disable_i,
        .comparator_uses_ref_i, .wdt_enable_i, .t2_async_i, .lcd_async_i,
        .t2_sync_i, .lcd_sync_i, .clock_source_fuses_i,
        .brownout_level_fuses_i, .on_chip_debug_fuse_i,
        .scan_port_enable_fuse_i, .clk_cpu_en_o,
        .clk_flash_en_o, .clk_io_en_o, .clk_adc_en_o, .clk_asy_en_o,
        .main_osc_en_o, .timer_osc_en_o, .periph_clk_en_o, .periph_io_block_o,
        .core_halt_o, .wake_o, .adc_start_o, .adc_extended_o, .adc_active_o,
        .comparator_off_o, .vref_en_o, .bod_active_o, .wdt_active_o,
        .input_buf_en_o, .scan_port_en_o);
    // start pulses last one cycle, so count them at every falling edge
    always @(negedge clk_i) if (adc_start_o === 1'b1) starts++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // classic cycle: hold until ack is sampled high at a rising edge,
    // take the data and release at that same edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (wb_ack_o !== 1'b1) begin
            errors++;
            $display("BAD %0t no bus acknowledge", $time);
        end
        // outputs launched by the access settle before anyone looks
        @(negedge clk_i);
    endtask
    task automatic doze(input logic [2:0] m);
        wb(1'b1, SLP_A_MODE, {28'h0, m, 1'b1});
        @(posedge clk_i);
        sleep_instr_i <= 1'b1;
        @(posedge clk_i);
        sleep_instr_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // count cycles until the core resumes; 1200 means it never did
    task automatic wait_wake(input int lo, input int hi);
        n = 1;
        do begin
            @(negedge clk_i);
            n++;
        end while (wake_o !== 1'b1 && n < 1200);
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask
    // raise one wake line and count cycles until the core resumes
    task automatic rouse(input logic [1:0] s, input int lo, input int hi);
        @(posedge clk_i);
        {fire, src} <= {1'b1, s};
        @(posedge clk_i);
        fire <= 1'b0;
        wait_wake(lo, hi);
    endtask
    task automatic s_regs;
        wb(1'b0, SLP_A_MODE, 32'h0);
        check(q, 32'h0);
        wb(1'b1, SLP_A_PWRRED, 32'h11);
        check(32'(periph_io_block_o), 32'h11);
        check(32'(periph_clk_en_o), 32'h0E);
        wb(1'b0, SLP_A_PWRRED, 32'h0);
        check(q, 32'h11);
        wb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        wb(1'b1, SLP_A_PWRRED, 32'h0);
        check(32'(periph_clk_en_o), 32'h1F);
    endtask
    task automatic s_refuse;
        wb(1'b1, SLP_A_MODE, 32'h0);
        @(posedge clk_i);
        sleep_instr_i <= 1'b1;
        @(posedge clk_i);
        sleep_instr_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        check(core_halt_o, 1'b0);
    endtask
    task automatic s_idle;
        @(posedge clk_i);
        adc_enable_i <= 1'b1;
        starts = 0;
        doze(SLP_M_IDLE);
        check({clk_cpu_en_o, clk_io_en_o, clk_adc_en_o}, 3'h3);
        check(clk_flash_en_o, 1'b0);
        check({adc_active_o, vref_en_o}, 2'h3);
        check(32'(starts), 32'h1);
        rouse(2'h0, 4, 10);
        doze(SLP_M_ADCNR);
        check({clk_cpu_en_o, clk_io_en_o, clk_adc_en_o}, 3'h1);
        check(32'(starts), 32'h2);
        rouse(2'h3, 4, 10);
        @(posedge clk_i);
        adc_enable_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        check({adc_active_o, adc_extended_o}, 2'h1);
        check(vref_en_o, 1'b0);
    endtask
    // power-save: timer2 wakes only once its enable is set
    task automatic s_psave;
        doze(SLP_M_PSAVE);
        check({clk_asy_en_o, timer_osc_en_o, main_osc_en_o}, 3'h4);
        @(posedge clk_i);
        {t2_ovf_flag_i, t2_async_i, t2_sync_i} <= 3'h7;
        repeat (3) @(negedge clk_i);
        check({core_halt_o, timer_osc_en_o, main_osc_en_o}, 3'h7);
        @(posedge clk_i);
        timer2_interrupt_mask_i <= 2'h1;
        wait_wake(20, 30);
        @(posedge clk_i);
        {t2_ovf_flag_i, t2_async_i, t2_sync_i, timer2_interrupt_mask_i} <= '0;
    endtask
    // debug keeps the main source in power-down until the port is disabled
    task automatic s_debug;
        @(posedge clk_i);
        {on_chip_debug_fuse_i, scan_port_enable_fuse_i} <= 2'h3;
        doze(SLP_M_PDOWN);
        check({main_osc_en_o, scan_port_en_o}, 2'h3);
        rouse(2'h1, 20, 30);
        wb(1'b1, SLP_A_MCUCTL, 32'h80);
        check(scan_port_en_o, 1'b0);
        doze(SLP_M_PDOWN);
        check(main_osc_en_o, 1'b0);
        rouse(2'h1, 20, 30);
    endtask
    task automatic s_pdown;
        @(posedge clk_i);
        wdt_enable_i <= 1'b1;
        doze(SLP_M_PDOWN);
        check({clk_io_en_o, clk_adc_en_o, main_osc_en_o}, 3'h0);
        check({comparator_off_o, input_buf_en_o}, 2'h2);
        check({bod_active_o, wdt_active_o}, 2'h1);
        rouse(2'h0, 1200, 1200);
        check(core_halt_o, 1'b1);
        rouse(2'h1, 20, 30);
        @(posedge clk_i);
        clock_source_fuses_i <= 4'h1;
        doze(SLP_M_PDOWN);
        rouse(2'h1, 1030, 1040);
    endtask
    task automatic s_standby;
        doze(SLP_M_STANDBY);
        check(clk_io_en_o, 1'b1);
        rouse(2'h0, 4, 10);
        @(posedge clk_i);
        clock_source_fuses_i <= 4'h8;
        doze(SLP_M_STANDBY);
        check({clk_cpu_en_o, main_osc_en_o}, 2'h1);
        rouse(2'h2, 10, 18);
        doze(3'h4);
        check(clk_io_en_o, 1'b1);
        rouse(2'h0, 4, 10);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // hang guard, far beyond the longest wake sequence
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        wrap_up();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, sleep_instr_i} = '0;
        {fire, src, reset_wake_i, adc_done_irq_i, usi_start_irq_i} = '0;
        {t2_ovf_flag_i, t2_cmp_flag_i, spm_ee_irq_i, adc_enable_i} = '0;
        {adc_conv_start_i, comparator_disable_i, comparator_uses_ref_i} = '0;
        {wdt_enable_i, t2_async_i, lcd_async_i, t2_sync_i, lcd_sync_i} = '0;
        {on_chip_debug_fuse_i, scan_port_enable_fuse_i} = '0;
        {timer2_interrupt_mask_i, clock_source_fuses_i} = '0;
        {global_ie_i, wb_sel_i, brownout_level_fuses_i} = {1'b1, 4'hF, 3'h7};
        {errors, total_checks, starts} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_refuse();
        s_idle();
        s_psave();
        s_debug();
        s_pdown();
        s_standby();
        wrap_up();
    end
endmodule
`default_nettype wire
